// File: src/eeprom_pkg.sv
// constants and types shared by the serial eeprom write control
package eeprom_pkg;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned PROG_TIME_NS = 10_000_000;
	localparam int unsigned PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned PROG_W = 22;
	localparam int unsigned ADDR_W = 9;
	localparam int unsigned PAGE_W = 6;
	localparam int unsigned COL_W = 3;
	localparam int unsigned PAGE_BYTES = 8;
	localparam logic [3:0] OP_HI_NIBBLE = 4'h0;
	localparam logic [2:0] OP_SET_LATCH = 3'h6;
	localparam logic [2:0] OP_STATUS = 3'h5;
	localparam logic [2:0] OP_WRITE = 3'h2;
	localparam int unsigned OP_TOP_ADDR_BIT = 3;
	localparam logic [7:0] STATUS_BUSY_BYTE = 8'hff;
	localparam logic [3:0] STATUS_IDLE_HI = 4'h0;
	localparam logic [1:0] LVL_NONE = 2'h0;
	localparam logic [1:0] LVL_QUARTER = 2'h1;
	localparam logic [1:0] LVL_HALF = 2'h2;
	localparam logic [1:0] LVL_ALL = 2'h3;
	localparam logic [1:0] QUARTER_TOP = 2'h3;
	localparam int unsigned PIN_CS = 0;
	localparam int unsigned PIN_SCK = 1;
	localparam int unsigned PIN_SI = 2;
	localparam int unsigned PIN_WP = 3;
	localparam int unsigned PIN_N = 4;
	localparam logic [3:0] PIN_RST = 4'h9;
	localparam logic [3:0] COMMIT_DONE = 4'h8;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPCODE,
		ST_ADDR,
		ST_DATA,
		ST_STATUS,
		ST_IGNORE
	} frame_e;
endpackage

// File: src/eeprom_write_ctrl.sv
// write-side control of a serial eeprom: frame decode, page buffer, timed programming
`timescale 1ns/1ps
// Contract
// - no programming starts while the write-protect input is low.
// - a write is accepted only if the write latch was set earlier.
// - bytes inside the selected protected range are never programmed.
// - while programming, every command except status read is ignored.
// - programming starts only when chip select rises after a valid write frame.
// - status bit 0 reads one while programming, zero once finished.
// - after each data byte only the three low address bits increment.
// - more than eight bytes wrap inside the page, overwriting earlier bytes.
// - the write latch clears itself when programming completes.
// - write with protect low or latch clear is discarded, standby at deselect.
// - after a discarded write, input is ignored until chip select falls again.
// - opcodes: upper nibble zero; set latch x110, status x101, write a010.
// - status holds busy, latch, two level bits; upper zero idle, all ones busy.
// - level 00 none, 01 top quarter, 10 top half, 11 whole array.
// - protect low during the frame aborts it; no effect once programming runs.
module eeprom_write_ctrl
	import eeprom_pkg::*;
#(
	parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// serial pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic wp_n,
	output logic so,
	output logic so_oe,
	// protection level
	input wire logic protect_level_hi,
	input wire logic protect_level_lo,
	// array write port
	output logic mem_we,
	output logic [ADDR_W-1:0] mem_addr,
	output logic [7:0] mem_data,
	// state
	output logic busy,
	output logic write_latch
);
	pin_link_if link();

	link_sampler u_sampler (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_raw({wp_n, si, sck, cs_n}),
		.link(link.src)
	);

	frame_e state_ff, nxt_state;
	logic [2:0] bit_cnt_ff, nxt_bit_cnt;
	logic [7:0] shift_ff, nxt_shift;
	logic [7:0] out_ff, nxt_out;
	logic addr_top_ff, nxt_addr_top;
	logic [PAGE_W-1:0] page_ff, nxt_page;
	logic [COL_W-1:0] col_ff, nxt_col;
	logic [7:0] buf_ff [PAGE_BYTES];
	logic [7:0] nxt_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] loaded_ff, nxt_loaded;
	logic wel_ff, nxt_wel;
	logic busy_ff, nxt_busy;
	logic [PROG_W-1:0] timer_ff, nxt_timer;
	logic [3:0] commit_ff, nxt_commit;
	logic so_ff, nxt_so;
	logic so_oe_ff, nxt_so_oe;
	logic mem_we_ff, nxt_mem_we;
	logic [ADDR_W-1:0] mem_addr_ff, nxt_mem_addr;
	logic [7:0] mem_data_ff, nxt_mem_data;
	logic [1:0] level;
	logic [7:0] status_byte;
	logic [7:0] rx_byte;
	logic [ADDR_W-1:0] commit_addr;

	function automatic logic is_protected(input logic [1:0] lvl, input logic [ADDR_W-1:0] a);
		logic hit;
		hit = 1'b0;
		unique case (lvl)
			LVL_NONE: hit = 1'b0;
			LVL_QUARTER: hit = (a[ADDR_W-1:ADDR_W-2] == QUARTER_TOP);
			LVL_HALF: hit = a[ADDR_W-1];
			LVL_ALL: hit = 1'b1;
		endcase
		return hit;
	endfunction

	assign level = {protect_level_hi, protect_level_lo};
	// busy forces every status bit high
	assign status_byte = busy_ff ? STATUS_BUSY_BYTE :
		{STATUS_IDLE_HI, level, wel_ff, busy_ff};
	assign rx_byte = {shift_ff[6:0], link.si};
	assign commit_addr = {page_ff, commit_ff[COL_W-1:0]};

	always_comb
	begin
		nxt_state = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_shift = shift_ff;
		nxt_out = out_ff;
		nxt_addr_top = addr_top_ff;
		nxt_page = page_ff;
		nxt_col = col_ff;
		nxt_buf = buf_ff;
		nxt_loaded = loaded_ff;
		nxt_wel = wel_ff;
		nxt_busy = busy_ff;
		nxt_timer = timer_ff;
		nxt_commit = commit_ff;
		nxt_so = so_ff;
		nxt_so_oe = so_oe_ff;
		nxt_mem_we = 1'b0;
		nxt_mem_addr = mem_addr_ff;
		nxt_mem_data = mem_data_ff;

		// programming runs on its own once started; only the protection level pins still gate the commit writes
		if (busy_ff)
		begin
			if (commit_ff != COMMIT_DONE)
			begin
				nxt_commit = commit_ff + 4'h1;
				nxt_mem_addr = commit_addr;
				nxt_mem_data = buf_ff[commit_ff[COL_W-1:0]];
				nxt_mem_we = loaded_ff[commit_ff[COL_W-1:0]]
					& ~is_protected(level, commit_addr);
			end
			if (timer_ff == '0)
			begin
				nxt_busy = 1'b0;
				nxt_wel = 1'b0;
				nxt_loaded = '0;
			end
			else
			begin
				nxt_timer = timer_ff - 1'b1;
			end
		end

		if (link.cs_rise)
		begin
			nxt_state = ST_IDLE;
			nxt_so_oe = 1'b0;
			// a trailing partial byte means a broken frame, so nothing is committed
			if (state_ff == ST_DATA && bit_cnt_ff == 3'h0 && loaded_ff != '0
				&& link.wp_n && !busy_ff)
			begin
				nxt_busy = 1'b1;
				nxt_timer = PROG_W'(PROG_CYCLES_P - 1);
				nxt_commit = 4'h0;
			end
			else if (!busy_ff)
			begin
				nxt_loaded = '0;
			end
		end
		else if (link.cs_fall)
		begin
			nxt_state = ST_OPCODE;
			nxt_bit_cnt = 3'h0;
		end
		else if (!link.cs_n)
		begin
			if ((state_ff == ST_ADDR || state_ff == ST_DATA) && !link.wp_n)
			begin
				nxt_state = ST_IGNORE;
			end
			else if (link.sck_rise && state_ff != ST_IGNORE && state_ff != ST_IDLE)
			begin
				nxt_shift = rx_byte;
				nxt_bit_cnt = bit_cnt_ff + 3'h1;
				if (bit_cnt_ff == 3'h7)
				begin
					unique case (state_ff)
						ST_OPCODE:
						begin
							nxt_state = ST_IGNORE;
							if (rx_byte[7:4] == OP_HI_NIBBLE)
							begin
								if (rx_byte[2:0] == OP_STATUS)
								begin
									nxt_state = ST_STATUS;
									nxt_so_oe = 1'b1;
								end
								else if (busy_ff)
								begin
									nxt_state = ST_IGNORE;
								end
								else if (rx_byte[2:0] == OP_SET_LATCH && link.wp_n)
								begin
									nxt_wel = 1'b1;
								end
								else if (rx_byte[2:0] == OP_WRITE && link.wp_n && wel_ff)
								begin
									nxt_state = ST_ADDR;
									nxt_addr_top = rx_byte[OP_TOP_ADDR_BIT];
									nxt_loaded = '0;
								end
							end
						end
						ST_ADDR:
						begin
							nxt_page = {addr_top_ff, rx_byte[7:COL_W]};
							nxt_col = rx_byte[COL_W-1:0];
							nxt_state = ST_DATA;
						end
						ST_DATA:
						begin
							nxt_buf[col_ff] = rx_byte;
							nxt_loaded[col_ff] = 1'b1;
							nxt_col = col_ff + 3'h1;
						end
						default:
						begin
							nxt_state = state_ff;
						end
					endcase
				end
			end
			else if (link.sck_fall && state_ff == ST_STATUS)
			begin
				// fresh status at each byte boundary so polling sees busy drop
				if (bit_cnt_ff == 3'h0)
				begin
					nxt_so = status_byte[7];
					nxt_out = {status_byte[6:0], 1'b0};
				end
				else
				begin
					nxt_so = out_ff[7];
					nxt_out = {out_ff[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_ff <= ST_IDLE;
			bit_cnt_ff <= 3'h0;
			shift_ff <= 8'h00;
			out_ff <= 8'h00;
			addr_top_ff <= 1'b0;
			page_ff <= '0;
			col_ff <= 3'h0;
			buf_ff <= '{default: 8'h00};
			loaded_ff <= '0;
			wel_ff <= 1'b0;
			busy_ff <= 1'b0;
			timer_ff <= '0;
			commit_ff <= COMMIT_DONE;
			so_ff <= 1'b0;
			so_oe_ff <= 1'b0;
			mem_we_ff <= 1'b0;
			mem_addr_ff <= '0;
			mem_data_ff <= 8'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff <= nxt_shift;
			out_ff <= nxt_out;
			addr_top_ff <= nxt_addr_top;
			page_ff <= nxt_page;
			col_ff <= nxt_col;
			buf_ff <= nxt_buf;
			loaded_ff <= nxt_loaded;
			wel_ff <= nxt_wel;
			busy_ff <= nxt_busy;
			timer_ff <= nxt_timer;
			commit_ff <= nxt_commit;
			so_ff <= nxt_so;
			so_oe_ff <= nxt_so_oe;
			mem_we_ff <= nxt_mem_we;
			mem_addr_ff <= nxt_mem_addr;
			mem_data_ff <= nxt_mem_data;
		end
	end

	assign so = so_ff;
	assign so_oe = so_oe_ff;
	assign mem_we = mem_we_ff;
	assign mem_addr = mem_addr_ff;
	assign mem_data = mem_data_ff;
	assign busy = busy_ff;
	assign write_latch = wel_ff;
endmodule

// File: src/link_sampler.sv
// two-flop synchronisers and edge finders for the serial pins
`timescale 1ns/1ps
module link_sampler
	import eeprom_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// raw pins
	input wire logic [PIN_N-1:0] pin_raw,
	// synchronised side
	pin_link_if.src link
);
	logic [PIN_N-1:0] meta_ff;
	logic [PIN_N-1:0] sync_ff;
	logic [PIN_N-1:0] prev_ff;

	// meta_ff feeds sync_ff only; edges come from sync_ff against prev_ff
	for (genvar i = 0; i < PIN_N; i++)
	begin : g_pin
		always_ff @(posedge clk_sys)
		begin
			if (rst)
			begin
				meta_ff[i] <= PIN_RST[i];
				sync_ff[i] <= PIN_RST[i];
				prev_ff[i] <= PIN_RST[i];
			end
			else
			begin
				meta_ff[i] <= pin_raw[i];
				sync_ff[i] <= meta_ff[i];
				prev_ff[i] <= sync_ff[i];
			end
		end
	end

	assign link.cs_n = sync_ff[PIN_CS];
	assign link.si = sync_ff[PIN_SI];
	assign link.wp_n = sync_ff[PIN_WP];
	assign link.sck_rise = sync_ff[PIN_SCK] & ~prev_ff[PIN_SCK];
	assign link.sck_fall = ~sync_ff[PIN_SCK] & prev_ff[PIN_SCK];
	assign link.cs_fall = ~sync_ff[PIN_CS] & prev_ff[PIN_CS];
	assign link.cs_rise = sync_ff[PIN_CS] & ~prev_ff[PIN_CS];
endmodule

// File: src/pin_link_if.sv
// synchronised serial pins and their edges, passed from the sampler to the controller
`timescale 1ns/1ps
interface pin_link_if;
	logic cs_n;
	logic si;
	logic wp_n;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;

	modport src (
		output cs_n,
		output si,
		output wp_n,
		output sck_rise,
		output sck_fall,
		output cs_fall,
		output cs_rise
	);
	modport dst (
		input cs_n,
		input si,
		input wp_n,
		input sck_rise,
		input sck_fall,
		input cs_fall,
		input cs_rise
	);
endinterface

// File: tb/eeprom_write_ctrl_sva.sv
// port assertions for the eeprom write control
`timescale 1ns/1ps
module eeprom_write_ctrl_sva
	import eeprom_pkg::*;
#(
	parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// pins and levels
	input wire logic cs_n,
	input wire logic so_oe,
	input wire logic protect_level_hi,
	input wire logic protect_level_lo,
	// outputs
	input wire logic mem_we,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic busy,
	input wire logic write_latch
);
	int cnt_ff;
	int nxt_cnt;
	logic hit;
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// busy is counted here because a repetition cannot unroll to this length
	always_comb
	begin
		nxt_cnt = busy ? cnt_ff + 1 : 0;
		hit = protect_level_hi && (protect_level_lo || mem_addr[8])
			|| protect_level_lo && mem_addr[8:7] == 2'b11;
	end
	always_ff @(posedge clk_sys)
	begin
		cnt_ff <= rst ? 0 : nxt_cnt;
	end
	AST_WE_BUSY: assert property (mem_we |-> busy && cnt_ff <= 8)
		else $error("write outside commit");
	AST_WE_PROT: assert property (mem_we |-> !hit)
		else $error("protected write");
	AST_WE_PAGE: assert property (mem_we ##1 mem_we |->
		mem_addr[8:3] == $past(mem_addr[8:3]) && mem_addr[2:0] > $past(mem_addr[2:0]))
		else $error("page order broken");
	AST_BUSY_LATCH: assert property ($rose(busy) |-> write_latch)
		else $error("busy without latch");
	AST_BUSY_LEN: assert property ($fell(busy) |-> cnt_ff == PROG_CYCLES_P)
		else $error("busy length");
	AST_LATCH_CLR: assert property ($fell(busy) |-> !write_latch)
		else $error("latch kept");
	AST_SO_IDLE: assert property (cs_n [*7] |-> !so_oe)
		else $error("output while deselected");
	AST_BUSY_HOLD: assert property ($rose(busy) |=> busy [*8])
		else $error("busy dropped");
	cover property ($fell(busy));
	cover property (mem_we && mem_addr[2:0] == 3'h7);
	cover property (so_oe && busy);
endmodule
bind eeprom_write_ctrl eeprom_write_ctrl_sva #(.PROG_CYCLES_P(PROG_CYCLES_P))
	i_eeprom_write_ctrl_sva (.clk_sys, .rst, .cs_n, .so_oe, .protect_level_hi,
	.protect_level_lo, .mem_we, .mem_addr, .busy, .write_latch);

// File: tb/eeprom_write_ctrl_tb_top.sv
// bench for the eeprom write control
`timescale 1ns/1ps
module eeprom_write_ctrl_tb_top
	import eeprom_pkg::*;
;
	localparam int PC = 1000;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic wp_n = 1'b1;
	logic lat_e = 1'b0;
	logic [1:0] lvl = 2'h0;
	logic cs_n, sck, si, so, so_oe, mem_we, busy, write_latch;
	logic so_line;
	logic [8:0] mem_addr;
	logic [7:0] mem_data, r;
	logic [7:0] cap [512] = '{default: 8'h00};
	logic [7:0] exp_m [512] = '{default: 8'h00};
	int seed = 32'h0814_080b;
	int bad_count = 0;
	int n_checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	eeprom_write_ctrl #(.PROG_CYCLES_P(PC)) i_eeprom_write_ctrl (.clk_sys, .rst, .cs_n, .sck,
		.si, .wp_n, .so, .so_oe, .protect_level_hi(lvl[1]), .protect_level_lo(lvl[0]),
		.mem_we, .mem_addr, .mem_data, .busy, .write_latch);
	// a released output shows the inverse, so a late enable spoils the status byte
	assign so_line = so_oe ? so : ~so;
	spi_master_model i_spi_master_model (.cs_n, .sck, .si, .so(so_line));
	always @(posedge clk_sys)
	begin
		if (mem_we === 1'b1)
			cap[mem_addr] <= mem_data;
	end
	function automatic logic hit(input logic [8:0] a);
		return lvl == 2'h3 || lvl == 2'h2 && a[8] || lvl == 2'h1 && a >= 9'h180;
	endfunction
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] ex);
		n_checks++;
		if (seen !== ex)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic send(input logic [7:0] q[$], input int cut = 0);
		@(negedge clk_sys);
		i_spi_master_model.frame(q, r, cut);
	endtask
	task automatic latch_on();
		send('{{4'h0, 1'($random(seed)), OP_SET_LATCH}});
		lat_e = wp_n;
		chk("latch", 8'(write_latch), 8'(lat_e));
	endtask
	task automatic status(input logic b);
		send('{{4'h0, 1'($random(seed)), OP_STATUS}, 8'h00});
		chk("status", r, b ? 8'hff : {4'h0, lvl, lat_e, 1'b0});
	endtask
	task automatic wr(input logic [8:0] a, input int n, input logic bz);
		logic [7:0] q[$];
		logic ok;
		ok = lat_e && wp_n && !bz;
		q = '{{4'h0, a[8], OP_WRITE}, a[7:0]};
		for (int i = 0; i < n; i++)
		begin
			q.push_back(8'($random(seed)));
			if (ok && !hit({a[8:3], 3'(a[2:0] + i)}))
				exp_m[{a[8:3], 3'(a[2:0] + i)}] = q[i + 2];
		end
		send(q);
		chk("busy", 8'(busy), 8'(ok || bz));
	endtask
	task automatic drain();
		for (int w = 0; w < 2 * PC && busy !== 1'b0; w++)
			@(negedge clk_sys);
		lat_e = 1'b0;
		chk("done", 8'({busy, write_latch}), 8'h00);
		foreach (cap[k])
			chk("mem", cap[k], exp_m[k]);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#400_000;
		bad_count++;
		finish_test();
	end
	initial
	begin
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		repeat (6) @(negedge clk_sys);
		chk("reset", 8'({so, so_oe, mem_we, busy, write_latch}), 8'h00);
		status(1'b0);
		wr(9'h005, 1, 1'b0);
		@(negedge clk_sys) wp_n = 1'b0;
		latch_on();
		@(negedge clk_sys) wp_n = 1'b1;
		latch_on();
		@(negedge clk_sys) wp_n = 1'b0;
		wr(9'h005, 1, 1'b0);
		@(negedge clk_sys) wp_n = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			@(negedge clk_sys) lvl = 2'(i);
			latch_on();
			wr(9'($random(seed)), 10, 1'b0);
			status(1'b1);
			wr(9'h000, 2, 1'b1);
			drain();
			status(1'b0);
		end
		@(negedge clk_sys) lvl = 2'h0;
		latch_on();
		fork
			send('{8'h02, 8'ha0, 8'h11, 8'h22});
			#1500 @(negedge clk_sys) wp_n = 1'b0;
		join
		chk("abort", 8'(busy), 8'h00);
		@(negedge clk_sys) wp_n = 1'b1;
		latch_on();
		send('{8'h12, 8'ha0, 8'h33});
		chk("bad_op", 8'(busy), 8'h00);
		send('{8'h02, 8'h50, 8'h44, 8'h55}, 3);
		chk("cut", 8'(busy), 8'h00);
		wr(9'h0a0, 3, 1'b0);
		@(negedge clk_sys) wp_n = 1'b0;
		drain();
		finish_test();
	end
endmodule

// File: tb/spi_master_model.sv
// serial master model driving the eeprom pins in mode 0
`timescale 1ns/1ps
module spi_master_model (
	// serial pins
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so
);
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b1;
	end
	// so is taken late in the high phase, long after it has settled
	// cut drops trailing bits of the last byte to model a broken frame
	task automatic frame(input logic [7:0] q[$], output logic [7:0] r, input int cut = 0);
		cs_n = 1'b0;
		#48;
		foreach (q[k])
		begin
			for (int i = 7; i >= (k == q.size() - 1 ? cut : 0); i--)
			begin
				si = q[k][i];
				#24 sck = 1'b1;
				#23 r = {r[6:0], so};
				#1 sck = 1'b0;
			end
		end
		#12 cs_n = 1'b1;
		si = ~si;
		#96;
	endtask
endmodule
